// [design/ssr_defines.svh]
// constants for the status register sets block
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

// ----------------------------------------
// word layout
// ----------------------------------------
`define SSR_W            15
`define SSR_ZEROS        15'h0000
`define SSR_ONES         15'h7FFF

// ----------------------------------------
// device set bit positions
// ----------------------------------------
`define SSR_DEV_CONN_A   1
`define SSR_DEV_CONN_B   2
`define SSR_DEV_ERR_A    3
`define SSR_DEV_ERR_B    4
`define SSR_DEV_REAR_A   5
`define SSR_DEV_REAR_B   6
`define SSR_DEV_KEY      14
`define SSR_DEV_USED_DUAL   15'h407E
`define SSR_DEV_USED_SINGLE 15'h402A

// ----------------------------------------
// operation set bit positions
// ----------------------------------------
`define SSR_OP_CAL       0
`define SSR_OP_MEAS      4
`define SSR_OP_TRIG      5
`define SSR_OP_SENSE     10
`define SSR_OP_LLF       11
`define SSR_OP_ULF       12
`define SSR_OP_USED      15'h1C31

// ----------------------------------------
// calibrating set bit positions
// ----------------------------------------
`define SSR_CAL_A        1
`define SSR_CAL_B        2
`define SSR_CAL_USED_DUAL   15'h0006
`define SSR_CAL_USED_SINGLE 15'h0002

`endif

// [design/ssr_pkg.sv]
// types shared by the status register sets block
package ssr_pkg;

	typedef enum logic [1:0] {SSR_SET_DEV, SSR_SET_OP, SSR_SET_CAL, SSR_SET_RSVD} ssr_set_t;

	typedef enum logic [2:0] {SSR_REG_COND, SSR_REG_EVENT, SSR_REG_ENABLE, SSR_REG_NTR, SSR_REG_PTR,
		SSR_REG_RSVD5, SSR_REG_RSVD6, SSR_REG_RSVD7} ssr_reg_t;

	typedef struct packed {
		logic [14:0] cond;
		logic [14:0] evt;
		logic [14:0] en;
		logic [14:0] falling_filter_short;
		logic [14:0] ptr;
	} ssr_set_state_t;

	typedef struct packed {
		logic [1:0] busy;
	} ssr_cal_state_t;

	typedef struct packed {
		logic        rsp_valid;
		logic        rsp_err;
		logic [15:0] rsp_data;
	} ssr_top_state_t;

endpackage

// [design/ssr_set.sv]
// one status register set: condition, filters, event latch, enable mask
`timescale 1ns/1ps
`include "ssr_defines.svh"

module ssr_set
	import ssr_pkg::*;
#(
	parameter logic [14:0] USED      = `SSR_ONES,
	parameter logic [14:0] EN_PRESET = `SSR_ONES
)(
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	// live inputs
	input  wire logic [14:0] cond_i,
	input  wire logic [14:0] direct_evt_i,
	input  wire logic        preset_i,
	// access
	input  wire logic        wr_i,
	input  wire logic        rd_evt_i,
	input  wire ssr_reg_t    reg_i,
	input  wire logic [15:0] wdata_i,
	// results
	output logic      [14:0] rd_word_o,
	output logic             summary_o
);

	ssr_set_state_t s_q;
	ssr_set_state_t s_d;
	logic [14:0]    cond_live;
	logic [14:0]    new_evt;

	assign cond_live = cond_i & USED;
	// filtered edges plus unfiltered sources
	assign new_evt = ((cond_live & ~s_q.cond & s_q.ptr)
		| (~cond_live & s_q.cond & s_q.falling_filter_short)
		| direct_evt_i) & USED;
	assign summary_o = |(s_q.evt & s_q.en);

	always_comb
	begin
		s_d      = s_q;
		s_d.cond = cond_live;
		// set wins over the read clear
		s_d.evt  = (rd_evt_i ? `SSR_ZEROS : s_q.evt) | new_evt;
		if (preset_i)
		begin
			s_d.en  = EN_PRESET;
			s_d.ptr = `SSR_ONES;
			s_d.falling_filter_short = `SSR_ZEROS;
		end
		else if (wr_i)
		begin
			case (reg_i)
				SSR_REG_ENABLE: s_d.en  = wdata_i[14:0];
				SSR_REG_NTR:    s_d.falling_filter_short = wdata_i[14:0];
				SSR_REG_PTR:    s_d.ptr = wdata_i[14:0];
				default:        s_d.en  = s_q.en;
			endcase
		end
	end

	always_comb
	begin
		case (reg_i)
			SSR_REG_COND:   rd_word_o = cond_live;
			SSR_REG_EVENT:  rd_word_o = s_q.evt;
			SSR_REG_ENABLE: rd_word_o = s_q.en;
			SSR_REG_NTR:    rd_word_o = s_q.falling_filter_short;
			SSR_REG_PTR:    rd_word_o = s_q.ptr;
			default:        rd_word_o = `SSR_ZEROS;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s_q.cond <= `SSR_ZEROS;
			s_q.evt  <= `SSR_ZEROS;
			s_q.en   <= EN_PRESET;
			s_q.falling_filter_short  <= `SSR_ZEROS;
			s_q.ptr  <= `SSR_ONES;
		end
		else
		begin
			s_q <= s_d;
		end
	end

endmodule

// [design/ssr_cal_track.sv]
// per-channel calibrating activity flags
`timescale 1ns/1ps
`include "ssr_defines.svh"

module ssr_cal_track
	import ssr_pkg::*;
#(
	parameter logic DUAL_CHAN = 1'b1
)(
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       resetn_i,
	// run events, bit 0 channel A, bit 1 channel B
	input  wire logic [1:0] zero_start_i,
	input  wire logic [1:0] cal_start_i,
	input  wire logic       cal_all_start_i,
	input  wire logic [1:0] run_done_i,
	// flags
	output logic      [1:0] busy_o
);

	ssr_cal_state_t s_q;
	ssr_cal_state_t s_d;
	logic [1:0]     chan_ok;
	logic [1:0]     start;

	assign chan_ok = {DUAL_CHAN, 1'b1};
	assign start   = (zero_start_i | cal_start_i
		| {2{cal_all_start_i}}) & chan_ok;
	assign busy_o  = s_q.busy;

	always_comb
	begin
		s_d = s_q;
		// a start in the done cycle keeps the flag
		s_d.busy = (s_q.busy & ~run_done_i) | start;
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s_q.busy <= 2'h0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

endmodule

// [design/ssr_top.sv]
// device, operation and calibrating status register sets with command port
`timescale 1ns/1ps
`include "ssr_defines.svh"

module ssr_top
	import ssr_pkg::*;
#(
	parameter logic DUAL_CHAN = 1'b1
)(
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	// status command port
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_write_i,
	input  wire ssr_set_t    cmd_set_i,
	input  wire ssr_reg_t    cmd_reg_i,
	input  wire logic [15:0] cmd_wdata_i,
	input  wire logic        preset_i,
	output logic             rsp_valid_o,
	output logic             rsp_err_o,
	output logic      [15:0] rsp_data_o,
	// sensor state, bit 0 channel A, bit 1 channel B
	input  wire logic [1:0]  sensor_conn_i,
	input  wire logic [1:0]  sensor_mem_fail_i,
	input  wire logic [1:0]  sensor_rear_i,
	input  wire logic        front_rear_both_i,
	input  wire logic        key_press_i,
	// calibration activity
	input  wire logic [1:0]  zero_start_i,
	input  wire logic [1:0]  cal_start_i,
	input  wire logic        cal_all_start_i,
	input  wire logic [1:0]  run_done_i,
	// summaries of the other operation sets
	input  wire logic        meas_sum_i,
	input  wire logic        trig_sum_i,
	input  wire logic        sense_sum_i,
	input  wire logic        llf_sum_i,
	input  wire logic        ulf_sum_i,
	// summaries towards the status byte
	output logic             dev_summary_o,
	output logic             op_summary_o
);

	localparam logic [14:0] DEV_USED = DUAL_CHAN ? `SSR_DEV_USED_DUAL : `SSR_DEV_USED_SINGLE;
	localparam logic [14:0] CAL_USED = DUAL_CHAN ? `SSR_CAL_USED_DUAL : `SSR_CAL_USED_SINGLE;

	ssr_top_state_t s_q;
	ssr_top_state_t s_d;

	logic [14:0] dev_cond;
	logic [14:0] dev_key;
	logic [14:0] op_cond;
	logic [14:0] cal_cond;
	logic [1:0]  cal_busy;
	logic        cal_summary;
	logic [14:0] dev_word;
	logic [14:0] op_word;
	logic [14:0] cal_word;
	logic        set_ok;
	logic        reg_ok;
	logic        wr_ok;
	logic        query;
	logic        wr_any;
	logic        rd_evt;
	logic        refused;
	logic        dev_wr;
	logic        op_wr;
	logic        cal_wr;
	logic        dev_rd_evt;
	logic        op_rd_evt;
	logic        cal_rd_evt;
	logic [14:0] sel_word;
	logic [1:0]  chan_conn;
	logic [1:0]  chan_err;
	logic [1:0]  chan_rear;
	logic [1:0]  chan_cal;

	// ----------------------------------------
	// per-channel status, bit 0 channel A, bit 1 channel B
	// ----------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1)
		begin
			assign chan_conn[ch] = sensor_conn_i[ch];
			assign chan_err[ch]  = sensor_mem_fail_i[ch] | front_rear_both_i;
			assign chan_rear[ch] = sensor_rear_i[ch];
			assign chan_cal[ch]  = cal_busy[ch];
		end
	endgenerate

	// ----------------------------------------
	// condition words
	// ----------------------------------------
	always_comb
	begin
		dev_cond = `SSR_ZEROS;
		dev_cond[`SSR_DEV_CONN_A] = chan_conn[0];
		dev_cond[`SSR_DEV_CONN_B] = chan_conn[1];
		dev_cond[`SSR_DEV_ERR_A]  = chan_err[0];
		dev_cond[`SSR_DEV_ERR_B]  = chan_err[1];
		dev_cond[`SSR_DEV_REAR_A] = chan_rear[0];
		dev_cond[`SSR_DEV_REAR_B] = chan_rear[1];
		// key press has no condition, only an event
		dev_cond[`SSR_DEV_KEY]    = 1'b0;
	end

	always_comb
	begin
		dev_key = `SSR_ZEROS;
		dev_key[`SSR_DEV_KEY] = key_press_i;
	end

	always_comb
	begin
		op_cond = `SSR_ZEROS;
		op_cond[`SSR_OP_CAL]   = cal_summary;
		op_cond[`SSR_OP_MEAS]  = meas_sum_i;
		op_cond[`SSR_OP_TRIG]  = trig_sum_i;
		op_cond[`SSR_OP_SENSE] = sense_sum_i;
		op_cond[`SSR_OP_LLF]   = llf_sum_i;
		op_cond[`SSR_OP_ULF]   = ulf_sum_i;
	end

	always_comb
	begin
		cal_cond = `SSR_ZEROS;
		cal_cond[`SSR_CAL_A] = chan_cal[0];
		cal_cond[`SSR_CAL_B] = chan_cal[1];
	end

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	// which sets exist
	always_comb
	begin
		set_ok = 1'b0;
		case (cmd_set_i)
			SSR_SET_DEV: set_ok = 1'b1;
			SSR_SET_OP:  set_ok = 1'b1;
			SSR_SET_CAL: set_ok = 1'b1;
			default:     set_ok = 1'b0;
		endcase
	end

	// which registers exist, and which of them take a write
	always_comb
	begin
		reg_ok = 1'b0;
		wr_ok  = 1'b0;
		case (cmd_reg_i)
			SSR_REG_COND:
			begin
				// condition is query only
				reg_ok = 1'b1;
				wr_ok  = 1'b0;
			end
			SSR_REG_EVENT:
			begin
				// event is query only
				reg_ok = 1'b1;
				wr_ok  = 1'b0;
			end
			SSR_REG_ENABLE:
			begin
				reg_ok = 1'b1;
				wr_ok  = 1'b1;
			end
			SSR_REG_NTR:
			begin
				reg_ok = 1'b1;
				wr_ok  = 1'b1;
			end
			SSR_REG_PTR:
			begin
				reg_ok = 1'b1;
				wr_ok  = 1'b1;
			end
			default:
			begin
				reg_ok = 1'b0;
				wr_ok  = 1'b0;
			end
		endcase
	end

	assign query   = cmd_valid_i & ~cmd_write_i & set_ok;
	assign wr_any  = cmd_valid_i & cmd_write_i & set_ok & wr_ok;
	assign rd_evt  = query & (cmd_reg_i == SSR_REG_EVENT);
	// refused commands change nothing and answer with an error
	assign refused = cmd_valid_i & (~set_ok | ~reg_ok | (cmd_write_i & ~wr_ok));

	// route the strobes to the addressed set only
	always_comb
	begin
		dev_wr     = 1'b0;
		op_wr      = 1'b0;
		cal_wr     = 1'b0;
		dev_rd_evt = 1'b0;
		op_rd_evt  = 1'b0;
		cal_rd_evt = 1'b0;
		case (cmd_set_i)
			SSR_SET_DEV:
			begin
				dev_wr     = wr_any;
				dev_rd_evt = rd_evt;
			end
			SSR_SET_OP:
			begin
				op_wr     = wr_any;
				op_rd_evt = rd_evt;
			end
			SSR_SET_CAL:
			begin
				cal_wr     = wr_any;
				cal_rd_evt = rd_evt;
			end
			default:
			begin
				dev_wr     = 1'b0;
				op_wr      = 1'b0;
				cal_wr     = 1'b0;
				dev_rd_evt = 1'b0;
				op_rd_evt  = 1'b0;
				cal_rd_evt = 1'b0;
			end
		endcase
	end

	// answer word of the addressed set
	always_comb
	begin
		sel_word = `SSR_ZEROS;
		case (cmd_set_i)
			SSR_SET_DEV: sel_word = dev_word;
			SSR_SET_OP:  sel_word = op_word;
			SSR_SET_CAL: sel_word = cal_word;
			default:     sel_word = `SSR_ZEROS;
		endcase
	end

	// ----------------------------------------
	// register sets
	// ----------------------------------------
	ssr_cal_track #(
		.DUAL_CHAN (DUAL_CHAN)
	) u_cal_track (
		.sys_clk_i       (sys_clk_i),
		.resetn_i        (resetn_i),
		.zero_start_i    (zero_start_i),
		.cal_start_i     (cal_start_i),
		.cal_all_start_i (cal_all_start_i),
		.run_done_i      (run_done_i),
		.busy_o          (cal_busy)
	);

	ssr_set #(
		.USED      (DEV_USED),
		.EN_PRESET (`SSR_ONES)
	) u_dev_set (
		.sys_clk_i    (sys_clk_i),
		.resetn_i     (resetn_i),
		.cond_i       (dev_cond),
		.direct_evt_i (dev_key),
		.preset_i     (preset_i),
		.wr_i         (dev_wr),
		.rd_evt_i     (dev_rd_evt),
		.reg_i        (cmd_reg_i),
		.wdata_i      (cmd_wdata_i),
		.rd_word_o    (dev_word),
		.summary_o    (dev_summary_o)
	);

	ssr_set #(
		.USED      (`SSR_OP_USED),
		.EN_PRESET (`SSR_ZEROS)
	) u_op_set (
		.sys_clk_i    (sys_clk_i),
		.resetn_i     (resetn_i),
		.cond_i       (op_cond),
		.direct_evt_i (`SSR_ZEROS),
		.preset_i     (preset_i),
		.wr_i         (op_wr),
		.rd_evt_i     (op_rd_evt),
		.reg_i        (cmd_reg_i),
		.wdata_i      (cmd_wdata_i),
		.rd_word_o    (op_word),
		.summary_o    (op_summary_o)
	);

	ssr_set #(
		.USED      (CAL_USED),
		.EN_PRESET (`SSR_ONES)
	) u_cal_set (
		.sys_clk_i    (sys_clk_i),
		.resetn_i     (resetn_i),
		.cond_i       (cal_cond),
		.direct_evt_i (`SSR_ZEROS),
		.preset_i     (preset_i),
		.wr_i         (cal_wr),
		.rd_evt_i     (cal_rd_evt),
		.reg_i        (cmd_reg_i),
		.wdata_i      (cmd_wdata_i),
		.rd_word_o    (cal_word),
		.summary_o    (cal_summary)
	);

	// ----------------------------------------
	// response register
	// ----------------------------------------
	always_comb
	begin
		s_d           = s_q;
		s_d.rsp_valid = cmd_valid_i;
		s_d.rsp_err   = refused;
		s_d.rsp_data  = 16'h0000;
		if (query)
		begin
			// bit 15 of every answer is zero
			s_d.rsp_data = {1'b0, sel_word};
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s_q.rsp_valid <= 1'b0;
			s_q.rsp_err   <= 1'b0;
			s_q.rsp_data  <= 16'h0000;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign rsp_valid_o = s_q.rsp_valid;
	assign rsp_err_o   = s_q.rsp_err;
	assign rsp_data_o  = s_q.rsp_data;

endmodule

// [tb/ssr_top_sva.sv]
// checker for the status register sets command port
`timescale 1ns/1ps

module ssr_top_sva
	import ssr_pkg::*;
#(
	parameter logic DUAL_CHAN = 1'b1
)(
	// clock and reset
	input wire logic        sys_clk_i,
	input wire logic        resetn_i,
	// command port
	input wire logic        cmd_valid_i,
	input wire logic        cmd_write_i,
	input wire ssr_set_t    cmd_set_i,
	input wire ssr_reg_t    cmd_reg_i,
	input wire logic        rsp_valid_o,
	input wire logic        rsp_err_o,
	input wire logic [15:0] rsp_data_o,
	// live status
	input wire logic [1:0]  sensor_conn_i,
	input wire logic [1:0]  sensor_mem_fail_i,
	input wire logic [1:0]  sensor_rear_i,
	input wire logic        front_rear_both_i,
	input wire logic        meas_sum_i,
	input wire logic        trig_sum_i
);
	// ----
	// helpers
	// ----
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);
	logic [1:0] b_mask;
	logic       dev_rd;
	logic       op_rd;
	assign b_mask = {DUAL_CHAN, 1'b1};
	assign dev_rd = cmd_valid_i && !cmd_write_i && cmd_set_i == SSR_SET_DEV && cmd_reg_i == SSR_REG_COND;
	assign op_rd  = cmd_valid_i && !cmd_write_i && cmd_set_i == SSR_SET_OP && cmd_reg_i == SSR_REG_COND;
	// ----
	// assertions
	// ----
	a_answer_next: assert property (cmd_valid_i |=> rsp_valid_o)
		else $error("command without answer");
	a_no_stray: assert property (!cmd_valid_i |=> !rsp_valid_o && !rsp_err_o)
		else $error("answer without command");
	a_top_bit_zero: assert property (rsp_valid_o |-> !rsp_data_o[15])
		else $error("answer bit 15 set");
	a_cond_write_refused: assert property (cmd_valid_i && cmd_write_i && cmd_reg_i == SSR_REG_COND
		|=> rsp_err_o && rsp_data_o == 16'h0000) else $error("condition write taken");
	a_key_cond_zero: assert property (dev_rd |=> !rsp_data_o[14])
		else $error("key bit in condition");
	a_conn_live: assert property (dev_rd && $stable(sensor_conn_i)
		|=> rsp_data_o[2:1] == ($past(sensor_conn_i) & b_mask)) else $error("presence bits wrong");
	a_err_live: assert property (dev_rd && $stable(sensor_mem_fail_i) && $stable(front_rear_both_i)
		|=> rsp_data_o[4:3] == (($past(sensor_mem_fail_i) | {2{$past(front_rear_both_i)}}) & b_mask))
		else $error("error bits wrong");
	a_rear_live: assert property (dev_rd && $stable(sensor_rear_i)
		|=> rsp_data_o[6:5] == ($past(sensor_rear_i) & b_mask)) else $error("rear bits wrong");
	a_op_bits: assert property (op_rd && $stable(meas_sum_i) && $stable(trig_sum_i)
		|=> rsp_data_o[5:4] == {$past(trig_sum_i), $past(meas_sum_i)}) else $error("operation bits wrong");
	a_op_top_zero: assert property (op_rd |=> rsp_data_o[15:13] == 3'h0)
		else $error("operation top bits set");
endmodule

bind ssr_top ssr_top_sva #(.DUAL_CHAN(DUAL_CHAN)) u_ssr_top_sva (
	.sys_clk_i        (sys_clk_i),
	.resetn_i         (resetn_i),
	.cmd_valid_i      (cmd_valid_i),
	.cmd_write_i      (cmd_write_i),
	.cmd_set_i        (cmd_set_i),
	.cmd_reg_i        (cmd_reg_i),
	.rsp_valid_o      (rsp_valid_o),
	.rsp_err_o        (rsp_err_o),
	.rsp_data_o       (rsp_data_o),
	.sensor_conn_i    (sensor_conn_i),
	.sensor_mem_fail_i(sensor_mem_fail_i),
	.sensor_rear_i    (sensor_rear_i),
	.front_rear_both_i(front_rear_both_i),
	.meas_sum_i       (meas_sum_i),
	.trig_sum_i       (trig_sum_i)
);

// [tb/ssr_host_model.sv]
// remote host model issuing status commands
`timescale 1ns/1ps

module ssr_host_model
	import ssr_pkg::*;
(
	// clock
	input  wire logic        sys_clk_i,
	// command port
	output logic             cmd_valid_o,
	output logic             cmd_write_o,
	output ssr_set_t         cmd_set_o,
	output ssr_reg_t         cmd_reg_o,
	output logic      [15:0] cmd_wdata_o,
	// answer
	input  wire logic        rsp_valid_i,
	input  wire logic        rsp_err_i,
	input  wire logic [15:0] rsp_data_i
);
	initial
	begin
		cmd_valid_o = 1'b0;
		cmd_write_o = 1'b0;
		cmd_set_o   = SSR_SET_DEV;
		cmd_reg_o   = SSR_REG_COND;
		cmd_wdata_o = 16'h0000;
	end
	// one command; answer read once it has settled in the cycle after
	task automatic xfer(input logic wr, input ssr_set_t s, input ssr_reg_t r, input logic [15:0] v,
		output logic [15:0] d, output logic e);
		@(posedge sys_clk_i);
		cmd_valid_o <= 1'b1;
		cmd_write_o <= wr;
		cmd_set_o   <= s;
		cmd_reg_o   <= r;
		cmd_wdata_o <= v;
		@(posedge sys_clk_i);
		cmd_valid_o <= 1'b0;
		cmd_wdata_o <= ~v;
		#1;
		d = rsp_data_i;
		e = rsp_valid_i ? rsp_err_i : 1'bx;
	endtask
endmodule

// [tb/ssr_top_bench.sv]
// self-checking bench for the status register sets block
`timescale 1ns/1ps

module ssr_top_bench
	import ssr_pkg::*;
();
	logic        sys_clk;
	logic        resetn;
	logic        cmd_valid;
	logic        cmd_write;
	ssr_set_t    cmd_set;
	ssr_reg_t    cmd_reg;
	logic [15:0] cmd_wdata;
	logic        rsp_valid;
	logic        rsp_err;
	logic [15:0] rsp_data;
	logic        preset;
	logic [1:0]  conn;
	logic [1:0]  mem_fail;
	logic [1:0]  rear;
	logic        both;
	logic        key;
	logic [1:0]  zstart;
	logic [1:0]  cstart;
	logic        call;
	logic [1:0]  done;
	logic [4:0]  op_in;
	logic        dev_sum;
	logic        op_sum;
	logic [15:0] d;
	logic        e;
	int          mismatches;
	int          tests_run;
	int          cycles;
	ssr_top u_ssr_top (.sys_clk_i(sys_clk), .resetn_i(resetn), .cmd_valid_i(cmd_valid),
		.cmd_write_i(cmd_write), .cmd_set_i(cmd_set), .cmd_reg_i(cmd_reg), .cmd_wdata_i(cmd_wdata),
		.preset_i(preset), .rsp_valid_o(rsp_valid), .rsp_err_o(rsp_err), .rsp_data_o(rsp_data),
		.sensor_conn_i(conn), .sensor_mem_fail_i(mem_fail), .sensor_rear_i(rear), .front_rear_both_i(both),
		.key_press_i(key), .zero_start_i(zstart), .cal_start_i(cstart), .cal_all_start_i(call),
		.run_done_i(done), .meas_sum_i(op_in[4]), .trig_sum_i(op_in[3]), .sense_sum_i(op_in[2]),
		.llf_sum_i(op_in[1]), .ulf_sum_i(op_in[0]), .dev_summary_o(dev_sum), .op_summary_o(op_sum));
	ssr_host_model u_ssr_host_model (.sys_clk_i(sys_clk), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
		.cmd_set_o(cmd_set), .cmd_reg_o(cmd_reg), .cmd_wdata_o(cmd_wdata), .rsp_valid_i(rsp_valid),
		.rsp_err_i(rsp_err), .rsp_data_i(rsp_data));
	// ----
	// helpers
	// ----
	task automatic complete_run();
		if (mismatches == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input ssr_set_t s, input ssr_reg_t r, input logic [15:0] exp);
		u_ssr_host_model.xfer(1'b0, s, r, 16'h0000, d, e);
		chk(d, exp);
	endtask
	task automatic wr(input ssr_set_t s, input ssr_reg_t r, input logic [15:0] v);
		u_ssr_host_model.xfer(1'b1, s, r, v, d, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// ----
	// scenarios
	// ----
	task automatic s_presets();
		rd(SSR_SET_DEV, SSR_REG_ENABLE, 16'h7FFF);
		rd(SSR_SET_OP, SSR_REG_ENABLE, 16'h0000);
		rd(SSR_SET_CAL, SSR_REG_ENABLE, 16'h7FFF);
		rd(SSR_SET_DEV, SSR_REG_PTR, 16'h7FFF);
		rd(SSR_SET_OP, SSR_REG_NTR, 16'h0000);
	endtask
	task automatic s_store();
		for (int i = 2; i <= 4; i++)
		begin
			wr(SSR_SET_DEV, ssr_reg_t'(i[2:0]), 16'hD5AA);
			chk({15'h0000, e}, 16'h0000);
			rd(SSR_SET_DEV, ssr_reg_t'(i[2:0]), 16'h55AA);
		end
	endtask
	task automatic s_presence();
		wr(SSR_SET_DEV, SSR_REG_PTR, 16'h0002);
		wr(SSR_SET_DEV, SSR_REG_NTR, 16'h0002);
		rd(SSR_SET_DEV, SSR_REG_EVENT, 16'h0000);
		@(posedge sys_clk);
		conn <= 2'b01;
		tick(2);
		rd(SSR_SET_DEV, SSR_REG_EVENT, 16'h0002);
		rd(SSR_SET_DEV, SSR_REG_EVENT, 16'h0000);
		@(posedge sys_clk);
		conn <= 2'b00;
		tick(2);
		rd(SSR_SET_DEV, SSR_REG_EVENT, 16'h0002);
	endtask
	task automatic s_dev_cond();
		@(posedge sys_clk);
		conn <= 2'b11;
		mem_fail <= 2'b01;
		rear <= 2'b10;
		tick(2);
		rd(SSR_SET_DEV, SSR_REG_COND, 16'h004E);
		rd(SSR_SET_DEV, SSR_REG_COND, 16'h004E);
		@(posedge sys_clk);
		both <= 1'b1;
		tick(2);
		rd(SSR_SET_DEV, SSR_REG_COND, 16'h005E);
		@(posedge sys_clk);
		conn <= 2'b00;
		mem_fail <= 2'b00;
		rear <= 2'b00;
		both <= 1'b0;
	endtask
	task automatic s_key();
		wr(SSR_SET_DEV, SSR_REG_PTR, 16'h0000);
		wr(SSR_SET_DEV, SSR_REG_NTR, 16'h0000);
		rd(SSR_SET_DEV, SSR_REG_EVENT, 16'h0002);
		@(posedge sys_clk);
		key <= 1'b1;
		@(posedge sys_clk);
		key <= 1'b0;
		tick(1);
		chk({15'h0000, dev_sum}, 16'h0001);
		rd(SSR_SET_DEV, SSR_REG_COND, 16'h0000);
		rd(SSR_SET_DEV, SSR_REG_EVENT, 16'h4000);
		chk({15'h0000, dev_sum}, 16'h0000);
	endtask
	task automatic s_op();
		@(posedge sys_clk);
		op_in <= 5'h1F;
		tick(2);
		rd(SSR_SET_OP, SSR_REG_COND, 16'h1C30);
		@(posedge sys_clk);
		op_in <= 5'h00;
	endtask
	task automatic s_cal();
		@(posedge sys_clk);
		zstart <= 2'b01;
		@(posedge sys_clk);
		zstart <= 2'b00;
		cstart <= 2'b10;
		@(posedge sys_clk);
		cstart <= 2'b00;
		tick(1);
		rd(SSR_SET_CAL, SSR_REG_COND, 16'h0006);
		@(posedge sys_clk);
		done <= 2'b11;
		@(posedge sys_clk);
		done <= 2'b00;
		tick(1);
		rd(SSR_SET_CAL, SSR_REG_COND, 16'h0000);
		@(posedge sys_clk);
		call <= 1'b1;
		@(posedge sys_clk);
		call <= 1'b0;
		tick(1);
		rd(SSR_SET_CAL, SSR_REG_COND, 16'h0006);
		rd(SSR_SET_OP, SSR_REG_COND, 16'h0001);
		wr(SSR_SET_OP, SSR_REG_ENABLE, 16'h0001);
		chk({15'h0000, op_sum}, 16'h0001);
	endtask
	task automatic s_refused();
		u_ssr_host_model.xfer(1'b0, SSR_SET_RSVD, SSR_REG_COND, 16'h0000, d, e);
		chk({15'h0000, e}, 16'h0001);
		wr(SSR_SET_DEV, SSR_REG_COND, 16'h7FFF);
		chk({15'h0000, e}, 16'h0001);
		rd(SSR_SET_DEV, SSR_REG_RSVD5, 16'h0000);
		chk({15'h0000, e}, 16'h0001);
	endtask
	// ----
	// main sequence
	// ----
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			mismatches++;
			complete_run();
		end
	end
	initial
	begin
		{resetn, preset, conn, mem_fail, rear, both, key} = '0;
		{zstart, cstart, call, done, op_in} = '0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		s_presets();
		s_store();
		s_presence();
		s_dev_cond();
		s_key();
		s_op();
		s_cal();
		s_refused();
		@(posedge sys_clk);
		preset <= 1'b1;
		@(posedge sys_clk);
		preset <= 1'b0;
		s_presets();
		complete_run();
	end
endmodule
